// File: logic/cic_map.vh
// Address map, command codes, function and trigger mode codes and timing counts for the counter channel block.
`ifndef CIC_MAP_VH
`define CIC_MAP_VH
`define CIC_NCH          5
`define CIC_OFF_CMD      8'h00
`define CIC_OFF_STATUS   8'h04
`define CIC_OFF_SAMPLE   8'h08
`define CIC_CH_BASE_HI   4'h2
`define CIC_CH_LAST_HI   4'h6
`define CIC_SUB_MODE_SELECT_CMD     2'h0
`define CIC_SUB_TRIG     2'h1
`define CIC_SUB_LIMIT    2'h2
`define CIC_SUB_RESULT   2'h3
`define CIC_CMD_ALLOW    4'h1
`define CIC_CMD_BLOCK    4'h2
`define CIC_CMD_CLEAR    4'h3
`define CIC_CMD_SERVICE  4'h4
`define CIC_CMD_FIRE     4'h5
`define CIC_CMD_SYSFIRE  4'h6
`define CIC_CMD_CODE_LSB 0
`define CIC_CMD_CH_LSB   8
`define CIC_FN_ACC       4'h0
`define CIC_FN_ACCW      4'h1
`define CIC_FN_BIDIR     4'h2
`define CIC_FN_BIDIRW    4'h3
`define CIC_FN_DIRG      4'h4
`define CIC_FN_DIRGW     4'h5
`define CIC_FN_QUOT      4'h6
`define CIC_FN_CYCLE     4'h7
`define CIC_FN_DCYCLE    4'h8
`define CIC_FN_FREQ      4'h9
`define CIC_MODE_SUSP    3'h0
`define CIC_MODE_OUTSIDE 3'h1
`define CIC_MODE_SHARED  3'h2
`define CIC_MODE_SHOT    3'h3
`define CIC_MODE_FREE    3'h4
`define CIC_MODE_SELECT_CMD_RST     4'h0
`define CIC_LIMIT_RST    16'h0001
`define CIC_SAMPLE_RST   16'h0001
`define CIC_CLK_HZ       125000000
`define CIC_GATE_MS      1000
`define CIC_GATE_CYC     ((`CIC_CLK_HZ / 1000) * `CIC_GATE_MS)
`define CIC_ST_PEND_LSB  0
`define CIC_ST_EN_LSB    8
`define CIC_ST_REQ_LSB   16
`define CIC_ST_CH_LSB    24
`define CIC_ST_ANY_BIT   27
`endif

// File: logic/cic_counter_irq.v
// Five-channel counter with interrupt request, trigger selection and result fetch behind an AHB-Lite slave.
// Contract
// - Accumulate channels enable overflow interrupt independently.
// - Measuring channels enable reading-available interrupt independently.
// - Tally functions never raise any interrupt.
// - Pending requests served lowest channel first.
// - Serviced overflow clears and disables.
// - Serviced reading-available disables, stays until read.
// - Slot clear disables all channel interrupts.
// - Overflow at -1 to 0, limit-1 to 0.
// - Quotient done after limit B periods.
// - Cycle-time done after limit A periods.
// - Frequency done when measurement finishes.
// - Block command disables addressed channel only.
// - Configuration writes abort measurement, discard data.
// - Function change keeps trigger source.
// - Outside pulse triggers all outside-mode channels.
// - System pulse triggers all shared-mode channels.
// - One-shot fires addressed channel; frequency fires all one-shot-mode channels.
// - Suspended stops everything; power-on default.
// - Free-running starts at once, retriggers itself.
// - Fetch returns live tally or last result.
// - Fetching completed result clears reading-available request.
// - Plain tallies wrap as 32-bit two's complement.
`timescale 1ns/1ps
`include "cic_map.vh"
module cic_counter_irq #(
  parameter GATE_CYC = `CIC_GATE_CYC
) (
  // Clock and reset.
  input  wire        ref_clk,
  input  wire        rst,
  // AHB-Lite slave.
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Channel inputs and trigger pins.
  input  wire [4:0]  chan_a,
  input  wire [4:0]  chan_b,
  input  wire        terminal_trigger_input,
  input  wire        mainframe_trigger_in,
  // Interrupt request toward the mainframe.
  output reg         irq_request,
  output reg  [2:0]  irq_channel
);
  localparam [31:0] GATE_LAST = GATE_CYC - 1;

  // Pin synchronisers: stage one feeds stage two only, stage three gives edges.
  reg  [11:0] sync1_reg;
  reg  [11:0] sync2_reg;
  reg  [11:0] sync3_reg;
  // Stage three exists only for edge detection; pins idle low, so leaving reset gives no false edge.
  wire [11:0] edge_v = sync2_reg & ~sync3_reg;
  wire [4:0]  a_edge = edge_v[4:0];
  wire [4:0]  b_edge = edge_v[9:5];
  wire [4:0]  b_lvl  = sync2_reg[9:5];
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 12'h000;
      sync2_reg <= 12'h000;
      sync3_reg <= 12'h000;
    end else begin
      sync1_reg <= {mainframe_trigger_in, terminal_trigger_input, chan_b, chan_a};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Bus address phase capture; the slave never inserts wait states.
  wire       take    = hsel & htrans[1] & hready;
  wire [7:0] ra      = haddr[7:0];
  // Only the write flag and address are kept; hwdata is read live in the data phase.
  reg        wr_reg;
  reg  [7:0] wa_reg;
  reg  [15:0] sample_reg;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_reg    <= 1'b0;
      wa_reg    <= 8'h00;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_reg    <= take & hwrite;
      wa_reg    <= ra;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Data-phase write strobes.
  wire       ch_wr   = wr_reg && wa_reg[7:4] >= `CIC_CH_BASE_HI && wa_reg[7:4] <= `CIC_CH_LAST_HI;
  wire [3:0] wch     = wa_reg[7:4] - `CIC_CH_BASE_HI;
  wire       cmd_wr  = wr_reg && wa_reg == `CIC_OFF_CMD;
  wire       samp_wr = wr_reg && wa_reg == `CIC_OFF_SAMPLE;
  wire [3:0] cmd     = hwdata[`CIC_CMD_CODE_LSB +: 4];
  wire [2:0] cch     = hwdata[`CIC_CMD_CH_LSB +: 3];
  // The system pin and the software system trigger share one path to the shared-mode channels.
  wire       sys_fire = edge_v[11] | (cmd_wr && cmd == `CIC_CMD_SYSFIRE);
  wire       out_fire = edge_v[10];

  // Sample interval is shared by all channels; changing it aborts every channel.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sample_reg <= `CIC_SAMPLE_RST;
    end else if (samp_wr) begin
      sample_reg <= hwdata[15:0];
    end
  end

  // Per-channel views collected from the generate loop.
  wire [4:0]   pend_v;
  wire [4:0]   en_v;
  wire [4:0]   req_v;
  wire [19:0]  fn_v;
  wire [159:0] rd_v;

  // Lowest presented channel wins service.
  reg [2:0] low_idx;
  reg       low_any;
  integer   k;
  always @* begin
    low_idx = 3'h0;
    low_any = 1'b0;
    for (k = `CIC_NCH - 1; k >= 0; k = k - 1) begin
      if (req_v[k]) begin
        low_idx = k[2:0];
        low_any = 1'b1;
      end
    end
  end
  // Service is ignored when nothing is presented.
  wire svc_cmd = cmd_wr && cmd == `CIC_CMD_SERVICE && low_any;
  // A one-shot fire on a frequency channel fires every channel in one-shot mode together.
  wire fire_cmd = cmd_wr && cmd == `CIC_CMD_FIRE && cch < `CIC_NCH;
  wire fire_all = fire_cmd && fn_v[cch * 4 +: 4] == `CIC_FN_FREQ;

  genvar i;
  generate
    for (i = 0; i < `CIC_NCH; i = i + 1) begin : g_ch
      reg  [3:0]  fn_reg;
      reg  [2:0]  mode_reg;
      reg  [15:0] lim_reg;
      reg  [31:0] cnt_reg;
      reg  [31:0] res_reg;
      reg  [15:0] per_reg;
      reg  [31:0] gate_reg;
      reg         run_reg;
      reg         en_reg;
      reg         pend_reg;
      reg         svcd_reg;

      // Register write strobes for this channel.
      wire        sel_w    = ch_wr && wch == i;
      wire        fn_wr    = sel_w && wa_reg[3:2] == `CIC_SUB_MODE_SELECT_CMD;
      wire        mode_wr  = sel_w && wa_reg[3:2] == `CIC_SUB_TRIG;
      wire        lim_wr   = sel_w && wa_reg[3:2] == `CIC_SUB_LIMIT;
      wire        pre_wr   = sel_w && wa_reg[3:2] == `CIC_SUB_RESULT;
      wire        abort    = fn_wr | mode_wr | lim_wr | pre_wr | samp_wr;
      // Function classes: tallies never interrupt, measuring functions report on completion.
      wire        tally    = fn_reg >= `CIC_FN_BIDIR && fn_reg <= `CIC_FN_DIRGW;
      wire        cmpl     = fn_reg >= `CIC_FN_QUOT;
      wire        is_ovf   = fn_reg == `CIC_FN_ACC || fn_reg == `CIC_FN_ACCW;
      // A limit of zero is not guarded: the wrap point then becomes ffff.
      wire [15:0] lim_m1   = lim_reg - 16'h0001;
      wire [2:0]  new_mode = mode_wr ? hwdata[2:0] : mode_reg;
      wire        at_top   = cnt_reg[15:0] == lim_m1;
      wire        last_per = per_reg == lim_m1;
      // Service reaches the lowest presented channel only; a fetch acts in its address phase.
      wire        my_hit   = svc_cmd && low_idx == i;
      wire        rd_res   = take && !hwrite && ra[7:4] == `CIC_CH_BASE_HI + i && ra[3:2] == `CIC_SUB_RESULT;
      // Triggers per mode; outside and shared pulses reach every channel in that mode at once.
      wire start = (mode_reg == `CIC_MODE_OUTSIDE && out_fire) |
                   (mode_reg == `CIC_MODE_SHARED && sys_fire) |
                   (mode_reg == `CIC_MODE_SHOT && (fire_all || (fire_cmd && cch == i)));
      // Overflow only on accumulate functions.
      wire ovf = run_reg && a_edge[i] && ((fn_reg == `CIC_FN_ACC && cnt_reg == 32'hffffffff) ||
                                          (fn_reg == `CIC_FN_ACCW && at_top));
      // Completion of a measuring function.
      wire done = run_reg && ((fn_reg == `CIC_FN_QUOT && b_edge[i] && last_per) ||
                              ((fn_reg == `CIC_FN_CYCLE || fn_reg == `CIC_FN_DCYCLE) &&
                               a_edge[i] && last_per) ||
                              (fn_reg == `CIC_FN_FREQ && gate_reg == GATE_LAST));
      // Tallies never request; only the event matching the function counts.
      wire evt = !tally && (is_ovf ? ovf : done);

      // Configuration; the trigger mode is left alone when the function changes.
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          fn_reg   <= `CIC_MODE_SELECT_CMD_RST;
          mode_reg <= `CIC_MODE_SUSP;
          lim_reg  <= `CIC_LIMIT_RST;
        end else begin
          if (fn_wr) begin
            fn_reg <= hwdata[3:0];
          end
          if (mode_wr) begin
            mode_reg <= hwdata[2:0];
          end
          if (lim_wr) begin
            lim_reg <= hwdata[15:0];
          end
        end
      end

      // Measurement datapath; an abort zeroes all partial data, except that a result write loads cnt_reg with the written word.
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          run_reg  <= 1'b0;
          cnt_reg  <= 32'h00000000;
          res_reg  <= 32'h00000000;
          per_reg  <= 16'h0000;
          gate_reg <= 32'h00000000;
        end else if (abort) begin
          run_reg  <= new_mode == `CIC_MODE_FREE;
          cnt_reg  <= pre_wr ? hwdata : 32'h00000000;
          res_reg  <= 32'h00000000;
          per_reg  <= 16'h0000;
          gate_reg <= 32'h00000000;
        end else if (mode_reg == `CIC_MODE_SUSP) begin
          run_reg <= 1'b0;
        end else if (done) begin
          res_reg  <= cnt_reg;
          run_reg  <= mode_reg == `CIC_MODE_FREE;
          cnt_reg  <= 32'h00000000;
          per_reg  <= 16'h0000;
          gate_reg <= 32'h00000000;
        end else if (start && cmpl) begin
          run_reg  <= 1'b1;
          cnt_reg  <= 32'h00000000;
          per_reg  <= 16'h0000;
          gate_reg <= 32'h00000000;
        end else if (start) begin
          run_reg <= 1'b1;
        end else if (run_reg) begin
          case (fn_reg)
            `CIC_FN_ACC: begin
              if (a_edge[i]) cnt_reg <= cnt_reg + 32'h00000001;
            end
            `CIC_FN_ACCW: begin
              if (a_edge[i]) cnt_reg <= at_top ? 32'h00000000 : cnt_reg + 32'h00000001;
            end
            `CIC_FN_BIDIR: begin
              if (a_edge[i] && !b_edge[i]) cnt_reg <= cnt_reg + 32'h00000001;
              if (b_edge[i] && !a_edge[i]) cnt_reg <= cnt_reg - 32'h00000001;
            end
            `CIC_FN_BIDIRW: begin
              if (a_edge[i] && !b_edge[i]) cnt_reg <= at_top ? 32'h00000000 : cnt_reg + 32'h00000001;
              if (b_edge[i] && !a_edge[i]) cnt_reg <= cnt_reg == 32'h00000000 ? {16'h0000, lim_m1} :
                                                      cnt_reg - 32'h00000001;
            end
            `CIC_FN_DIRG: begin
              if (a_edge[i]) cnt_reg <= b_lvl[i] ? cnt_reg - 32'h00000001 : cnt_reg + 32'h00000001;
            end
            `CIC_FN_DIRGW: begin
              if (a_edge[i] && !b_lvl[i]) cnt_reg <= at_top ? 32'h00000000 : cnt_reg + 32'h00000001;
              if (a_edge[i] && b_lvl[i]) cnt_reg <= cnt_reg == 32'h00000000 ? {16'h0000, lim_m1} :
                                                    cnt_reg - 32'h00000001;
            end
            // Measuring functions count into cnt_reg and periods into per_reg, frequency its gate into gate_reg, until done.
            `CIC_FN_QUOT: begin
              if (a_edge[i]) cnt_reg <= cnt_reg + 32'h00000001;
              if (b_edge[i]) per_reg <= per_reg + 16'h0001;
            end
            `CIC_FN_CYCLE: begin
              cnt_reg <= cnt_reg + 32'h00000001;
              if (a_edge[i]) per_reg <= per_reg + 16'h0001;
            end
            `CIC_FN_DCYCLE: begin
              // Only the final period survives: earlier periods restart the timer.
              cnt_reg <= a_edge[i] ? 32'h00000000 : cnt_reg + 32'h00000001;
              if (a_edge[i]) per_reg <= per_reg + 16'h0001;
            end
            `CIC_FN_FREQ: begin
              if (a_edge[i]) cnt_reg <= cnt_reg + 32'h00000001;
              gate_reg <= gate_reg + 32'h00000001;
            end
            default: begin
              run_reg <= 1'b0;
            end
          endcase
        end
      end

      // Interrupt enable, pending latch and serviced mark; a new event beats any clear.
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          en_reg   <= 1'b0;
          pend_reg <= 1'b0;
          svcd_reg <= 1'b0;
        end else begin
          // Every disabling command wins over an allow that arrives in the same cycle.
          if (cmd_wr && cmd == `CIC_CMD_CLEAR) begin
            en_reg <= 1'b0;
          end else if (cmd_wr && cmd == `CIC_CMD_BLOCK && cch == i) begin
            en_reg <= 1'b0;
          end else if (my_hit) begin
            en_reg <= 1'b0;
          end else if (cmd_wr && cmd == `CIC_CMD_ALLOW && cch == i && !tally) begin
            en_reg <= 1'b1;
          end
          // A new event beats the service and fetch clears in the same cycle.
          if (evt && en_reg) begin
            pend_reg <= 1'b1;
            svcd_reg <= 1'b0;
          end else if (my_hit && is_ovf) begin
            pend_reg <= 1'b0;
            svcd_reg <= 1'b0;
          end else if (rd_res && cmpl) begin
            pend_reg <= 1'b0;
            svcd_reg <= 1'b0;
          end else if (my_hit) begin
            svcd_reg <= 1'b1;
          end
        end
      end

      assign pend_v[i] = pend_reg;
      assign en_v[i]   = en_reg;
      assign req_v[i]  = pend_reg & ~svcd_reg;
      assign fn_v[i * 4 +: 4] = fn_reg;
      // Read view: live count for counting functions, last completed result otherwise.
      assign rd_v[i * 32 +: 32] = ra[3:2] == `CIC_SUB_MODE_SELECT_CMD  ? {28'h0000000, fn_reg} :
                                  ra[3:2] == `CIC_SUB_TRIG  ? {29'h00000000, mode_reg} :
                                  ra[3:2] == `CIC_SUB_LIMIT ? {16'h0000, lim_reg} :
                                  (cmpl ? res_reg : cnt_reg);
    end
  endgenerate

  // Read mux in the address phase so data stand from a flip-flop in the data phase.
  wire [3:0]  rch    = ra[7:4] - `CIC_CH_BASE_HI;
  wire        rch_ok = ra[7:4] >= `CIC_CH_BASE_HI && ra[7:4] <= `CIC_CH_LAST_HI;
  reg  [31:0] rd_next;
  always @* begin
    rd_next = 32'h00000000;
    // Status mirrors the priority encoder that drives the request outputs.
    if (ra == `CIC_OFF_STATUS) begin
      rd_next[`CIC_ST_PEND_LSB +: 5] = pend_v;
      rd_next[`CIC_ST_EN_LSB +: 5]   = en_v;
      rd_next[`CIC_ST_REQ_LSB +: 5]  = req_v;
      rd_next[`CIC_ST_CH_LSB +: 3]   = low_idx;
      rd_next[`CIC_ST_ANY_BIT]       = low_any;
    end else if (ra == `CIC_OFF_SAMPLE) begin
      rd_next = {16'h0000, sample_reg};
    end else if (rch_ok) begin
      rd_next = rd_v[rch[2:0] * 32 +: 32];
    end
  end

  // Registered read data and interrupt request outputs.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hrdata      <= 32'h00000000;
      irq_request <= 1'b0;
      irq_channel <= 3'h0;
    end else begin
      if (take && !hwrite) begin
        hrdata <= rd_next;
      end
      // The request outputs lag the encoder by one clock so that they come from flip-flops.
      irq_request <= low_any;
      irq_channel <= low_idx;
    end
  end
endmodule

// File: tb/cic_counter_irq_properties.sv
// Port-level assertions for the counter channel interrupt block.
`timescale 1ns/1ps
module cic_counter_irq_chk #(
  parameter GATE_CYC = 20
) (
  // Clock and reset.
  input wire        ref_clk,
  input wire        rst,
  // Bus signals.
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // Interrupt outputs.
  input wire        irq_request,
  input wire [2:0]  irq_channel
);
  reg cmd_ph_reg;
  reg allow_reg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Remember whether software ever allowed an interrupt; without it none may be presented.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_ph_reg <= 1'b0;
      allow_reg  <= 1'b0;
    end else begin
      cmd_ph_reg <= hsel && htrans[1] && hwrite && hready && haddr[7:0] == 8'h00;
      if (cmd_ph_reg && hwdata[3:0] == 4'h1) allow_reg <= 1'b1;
    end
  end
  chk_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
  chk_ready_high: assert property (!$past(rst) |-> hreadyout) else $error("wait state inserted");
  chk_rdata_hold: assert property ($past(!(hsel && htrans[1] && !hwrite && hready)) |-> $stable(hrdata))
    else $error("read data changed without a read");
  chk_unmapped_zero: assert property (hsel && htrans[1] && !hwrite && hready && haddr[7:4] == 4'h1
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  chk_chan_range: assert property (irq_request |-> irq_channel <= 3'h4)
    else $error("presented channel out of range");
  chk_irq_fall_cause: assert property ($fell(irq_request) |->
    $past(htrans[1]) || $past(htrans[1], 2) || $past(htrans[1], 3)) else $error("request dropped by itself");
  chk_chan_up_cause: assert property (irq_request && $past(irq_request) && irq_channel > $past(irq_channel) |->
    $past(htrans[1]) || $past(htrans[1], 2) || $past(htrans[1], 3)) else $error("channel order broken");
  chk_irq_needs_allow: assert property (irq_request |-> allow_reg)
    else $error("request without any allow");
  cov_irq_rise: cover property ($rose(irq_request));
  cov_irq_ch3: cover property (irq_request && irq_channel == 3'h3);
  cov_irq_fall: cover property ($fell(irq_request));
endmodule
bind cic_counter_irq cic_counter_irq_chk #(.GATE_CYC(GATE_CYC)) i_chk (
  .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .irq_request, .irq_channel
);

// File: tb/cic_pin_src.sv
// Pin source model for the channel inputs and the two trigger wires.
`timescale 1ns/1ps
module cic_pin_src (
  // Clock.
  input  wire       ref_clk,
  // Pins toward the counter.
  output wire [4:0] chan_a,
  output wire [4:0] chan_b,
  output wire       term_trig,
  output wire       sys_trig
);
  reg [11:0] pins_reg = 12'h000;
  // Lines sit low between pulses, like an idle sensor output.
  assign chan_a    = pins_reg[4:0];
  assign chan_b    = pins_reg[9:5];
  assign term_trig = pins_reg[10];
  assign sys_trig  = pins_reg[11];
  // Pulses are 4 clocks high and at least 4 low so the two-flop synchroniser never misses one.
  task pulse(input int sel, input int ch, input int cnt);
    int idx;
    idx = (sel < 2) ? sel * 5 + ch : 8 + sel;
    repeat (cnt) begin
      @(posedge ref_clk);
      pins_reg[idx] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      pins_reg[idx] <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking testbench for the counter channel interrupt block.
`timescale 1ns/1ps
`include "cic_map.vh"
module tb_top;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        rd_ph = 1'b0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         irq_request;
  wire  [2:0]  irq_channel;
  wire  [4:0]  chan_a;
  wire  [4:0]  chan_b;
  wire         term_trig;
  wire         sys_trig;
  int          failures = 0;
  int          tests_run = 0;
  int          seed = 32'h6c48;
  int          n;
  int          k;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic [3:0]  fn [5] = '{`CIC_FN_CYCLE, `CIC_FN_ACCW, `CIC_FN_BIDIR, `CIC_FN_QUOT, `CIC_FN_DIRG};
  always #4 ref_clk = ~ref_clk;
  cic_pin_src i_src (.ref_clk(ref_clk), .chan_a(chan_a), .chan_b(chan_b), .term_trig(term_trig),
    .sys_trig(sys_trig));
  cic_counter_irq #(.GATE_CYC(20)) i_dut (.ref_clk(ref_clk), .rst(rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .chan_a(chan_a), .chan_b(chan_b),
    .terminal_trigger_input(term_trig), .mainframe_trigger_in(sys_trig),
    .irq_request(irq_request), .irq_channel(irq_channel));
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Bounded wait for the slave's ready; running out ends the run.
  task automatic wait_rdy;
    int cnt;
    cnt = 0;
    do begin
      @(posedge ref_clk);
      cnt++;
    end while (hreadyout !== 1'b1 && cnt < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      finish_test;
    end
  endtask
  // One single-word transfer; reads leave their expectation and mask in the queue.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge ref_clk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph  <= !w;
    if (!w) exp_q.push_back({m, d});
    wait_rdy;
    rd_ph  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hffffffff);
    xfer(1'b0, a, d, m);
  endtask
  task automatic cmd(input logic [3:0] code, input int ch);
    wr(`CIC_OFF_CMD, {21'h0, 3'(ch), 4'h0, code});
  endtask
  function automatic logic [7:0] ca(input int ch, input int sub);
    return 8'h20 + 8'(ch * 16 + sub * 4);
  endfunction
  // Interrupt outputs are sampled on the falling edge, well clear of their update.
  task automatic irq(input logic r, input logic [2:0] c);
    repeat (2) @(negedge ref_clk);
    chk("irq_request", {31'h0, r}, {31'h0, irq_request});
    if (r) chk("irq_channel", {29'h0, c}, {29'h0, irq_channel});
  endtask
  // Read data is taken at the edge that ends the data phase.
  always @(posedge ref_clk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      e = exp_q.pop_front();
      chk("hrdata", e[63:32] & e[31:0], e[63:32] & hrdata);
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    for (n = 0; n < 5; n++) begin
      rd(ca(n, 0), `CIC_MODE_SELECT_CMD_RST);
      rd(ca(n, 1), `CIC_MODE_SUSP);
      rd(ca(n, 2), `CIC_LIMIT_RST);
    end
    rd(`CIC_OFF_STATUS, 32'h0);
    rd(8'h14, 32'h0);
    // Functions are chosen while every channel is still suspended.
    for (n = 0; n < 5; n++) begin
      wr(ca(n, 0), fn[n]);
      cmd(`CIC_CMD_ALLOW, n);
    end
    rd(`CIC_OFF_STATUS, 32'h0000_0b00);
    cmd(`CIC_CMD_BLOCK, 1);
    rd(`CIC_OFF_STATUS, 32'h0000_0900);
    cmd(`CIC_CMD_CLEAR, 0);
    rd(`CIC_OFF_STATUS, 32'h0);
    wr(ca(1, 1), `CIC_MODE_FREE);
    wr(ca(1, 0), `CIC_FN_ACCW);
    rd(ca(1, 1), `CIC_MODE_FREE);
    wr(ca(1, 2), 32'h3);
    cmd(`CIC_CMD_ALLOW, 1);
    i_src.pulse(0, 1, 2);
    rd(ca(1, 3), 32'h2);
    irq(1'b0, 3'h0);
    i_src.pulse(0, 1, 1);
    irq(1'b1, 3'h1);
    k = 1 + ($random(seed) & 3);
    wr(ca(2, 1), `CIC_MODE_FREE);
    cmd(`CIC_CMD_ALLOW, 2);
    i_src.pulse(0, 2, k);
    rd(ca(2, 3), 32'(k));
    irq(1'b1, 3'h1);
    wr(ca(4, 1), `CIC_MODE_FREE);
    wr(ca(4, 3), 32'h7fff_ffff);
    i_src.pulse(0, 4, 1);
    rd(ca(4, 3), 32'h8000_0000);
    wr(ca(4, 2), 32'h5);
    rd(ca(4, 3), 32'h0);
    wr(ca(0, 1), `CIC_MODE_SHOT);
    cmd(`CIC_CMD_ALLOW, 0);
    cmd(`CIC_CMD_FIRE, 0);
    i_src.pulse(0, 0, 1);
    irq(1'b1, 3'h0);
    rd(`CIC_OFF_STATUS, 32'h0803_0303);
    cmd(`CIC_CMD_SERVICE, 0);
    irq(1'b1, 3'h1);
    rd(`CIC_OFF_STATUS, 32'h0902_0203);
    // One period of the pin costs three clocks: launch plus two synchroniser stages.
    rd(ca(0, 3), 32'h3);
    rd(`CIC_OFF_STATUS, 32'h2, 32'h1f);
    cmd(`CIC_CMD_SERVICE, 0);
    irq(1'b0, 3'h0);
    rd(`CIC_OFF_STATUS, 32'h0);
    // Outside pin first, then the shared system pulse, on the quotient channel.
    for (n = 0; n < 2; n++) begin
      wr(ca(3, 1), n ? `CIC_MODE_SHARED : `CIC_MODE_OUTSIDE);
      cmd(`CIC_CMD_ALLOW, 3);
      i_src.pulse(1, 3, 1);
      irq(1'b0, 3'h0);
      i_src.pulse(2 + n, 0, 1);
      i_src.pulse(0, 3, n + 1);
      i_src.pulse(1, 3, 1);
      irq(1'b1, 3'h3);
      rd(ca(3, 3), 32'(n + 1));
      irq(1'b0, 3'h0);
    end
    wr(ca(2, 0), `CIC_FN_FREQ);
    cmd(`CIC_CMD_ALLOW, 2);
    repeat (40) @(posedge ref_clk);
    irq(1'b1, 3'h2);
    finish_test;
  end
endmodule
